// [hw/jtctap_pkg.sv]
package jtctap_pkg;

   // ****************************************
   // State encoding
   // ****************************************
   typedef enum logic [15:0] {
      ST_RESET      = 16'h0001,
      ST_IDLE       = 16'h0002,
      ST_SEL_DR     = 16'h0004,
      ST_CAP_DR     = 16'h0008,
      ST_SHIFT_DR   = 16'h0010,
      ST_EXIT1_DR   = 16'h0020,
      ST_PAUSE_DR   = 16'h0040,
      ST_EXIT2_DR   = 16'h0080,
      ST_UPDATE_DR  = 16'h0100,
      ST_SEL_IR     = 16'h0200,
      ST_CAP_IR     = 16'h0400,
      ST_SHIFT_IR   = 16'h0800,
      ST_EXIT1_IR   = 16'h1000,
      ST_PAUSE_IR   = 16'h2000,
      ST_EXIT2_IR   = 16'h4000,
      ST_UPDATE_IR  = 16'h8000
   } jtctap_state_t;

   // ****************************************
   // Instruction codes
   // ****************************************
   localparam int IR_WIDTH = 3;
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_IDCODE = 3'h1;
   localparam logic [2:0] INS_SAMPLE = 3'h2;
   localparam logic [2:0] INS_CLAMP = 3'h3;
   localparam logic [2:0] INS_HIGHZ = 3'h4;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   localparam logic [2:0] IR_CAPTURE_VALUE = 3'h1;

   // ****************************************
   // Identification layout
   // ****************************************
   localparam int ID_WIDTH = 32;
   localparam logic [10:0] ID_MAKER_DEFAULT = 11'h000;
   localparam logic [15:0] ID_PART_DEFAULT = 16'h0000;
   localparam logic [3:0] ID_VERSION_DEFAULT = 4'h0;
   localparam logic ID_LSB = 1'b1;

   // ****************************************
   // Pin timing
   // ****************************************
   localparam int SYNC_STAGES = 2;
   localparam int BSR_WIDTH_DEFAULT = 8;

endpackage

// [hw/jtctap_sync.sv]
`timescale 1ns/1ps
module jtctap_sync
   import jtctap_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ****************************************
   // Two-stage synchroniser
   // ****************************************
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule

// [hw/jtctap_top.sv]
// How it works
// - State steps on sampled rising tap_clock, using sampled mode select; sampled tap reset low forces Test-Logic-Reset.
// - Powers up in Test-Logic-Reset; functional pins pass through normally.
// - Test-Logic-Reset forces IDCODE into the current instruction.
// - Run-Test-Idle leaves instruction and data registers untouched.
// - Select-DR: low to Capture-DR, high to Select-IR; registers hold.
// - Capture-DR loads the selected register; others keep their value.
// - Capture-DR: low to Shift-DR, high to Exit1-DR.
// - Shift-DR shifts selected register toward serial out; others hold.
// - Exit1-DR: high to Update-DR, low to Pause-DR.
// - Pause-DR holds registers; low stays, high to Exit2-DR.
// - Exit2-DR: high to Update-DR, low back to Shift-DR.
// - Update-DR latches shift path to parallel outputs on falling edge.
// - Select-IR holds registers; low to Capture-IR, high to Test-Logic-Reset.
// - Capture-IR loads fixed value; high to Exit1-IR, low to Shift-IR.
// - Shift-IR shifts instruction stage; high exits to Exit1-IR, low stays.
// - Supports SAMPLE, BYPASS, EXTEST, HIGHZ, CLAMP, IDCODE with optional reset.
// - Tolerates tap_clock halted high or low indefinitely.
// - Instruction register: 3-bit shift stage plus 3-bit latched output.
// - Codes: SAMPLE 010, BYPASS 111, EXTEST 000, CLAMP 011, HIGHZ 100, IDCODE 001.
// - Update-IR latches instruction on falling edge; low to Idle, high Select-DR.
// - ID register 32 bits: LSB one, maker 11, part 16, version 4.
`timescale 1ns/1ps
module jtctap_top
   import jtctap_pkg::*;
#(
   parameter int BSR_WIDTH = BSR_WIDTH_DEFAULT,
   parameter logic [10:0] ID_MAKER = ID_MAKER_DEFAULT,   // Arbitrary value
   parameter logic [15:0] ID_PART = ID_PART_DEFAULT,     // Arbitrary value
   parameter logic [3:0] ID_VERSION = ID_VERSION_DEFAULT // Arbitrary value
) (
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic TAP_CLOCK_IN,
   input wire logic TAP_MODE_SELECT_IN,
   input wire logic TAP_SERIAL_IN,
   input wire logic TAP_RESET_N_IN,
   input wire logic [BSR_WIDTH-1:0] CORE_OUT_IN,
   input wire logic [BSR_WIDTH-1:0] PIN_IN,
   output logic TAP_SERIAL_OUT,
   output logic TAP_SERIAL_OE_N_OUT,
   output logic [BSR_WIDTH-1:0] PIN_OUT,
   output logic PIN_OE_N_OUT,
   output logic [BSR_WIDTH-1:0] CORE_IN_OUT,
   output logic [IR_WIDTH-1:0] INSTRUCTION_OUT,
   output logic TAP_RESET_STATE_OUT
);

   // ****************************************
   // Input sampling
   // ****************************************
   localparam int PIN_CNT = 4;
   localparam int POS_TCK = 0;
   localparam int POS_TMS = 1;
   localparam int POS_TDI = 2;
   localparam int POS_TRST = 3;

   logic [PIN_CNT-1:0] raw_pins;
   logic [PIN_CNT-1:0] sync_pins;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic trst_n_s;

   assign raw_pins = {TAP_RESET_N_IN, TAP_SERIAL_IN, TAP_MODE_SELECT_IN, TAP_CLOCK_IN};

   jtctap_sync #(.WIDTH(PIN_CNT)) u_sync (
      .clk_in(CLOCK_IN),
      .rst_n_in(RESET_N_IN),
      .async_in(raw_pins),
      .sync_out(sync_pins)
   );

   assign tck_s = sync_pins[POS_TCK];
   assign tms_s = sync_pins[POS_TMS];
   assign tdi_s = sync_pins[POS_TDI];
   assign trst_n_s = sync_pins[POS_TRST];

   // ****************************************
   // Clock edge detection
   // ****************************************
   logic tck_prev_ff;
   logic [SYNC_STAGES:0] arm_ff;
   logic tck_rise;
   logic tck_fall;

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         tck_prev_ff <= 1'b0;
         arm_ff <= '0;
      end else begin
         tck_prev_ff <= tck_s;
         arm_ff <= {arm_ff[SYNC_STAGES-1:0], 1'b1};
      end
   end

   // Edges only on level change; a stopped clock simply yields none
   // No edges until the synchroniser holds real pin levels
   assign tck_rise = arm_ff[SYNC_STAGES] & tck_s & ~tck_prev_ff;
   assign tck_fall = arm_ff[SYNC_STAGES] & ~tck_s & tck_prev_ff;

   // ****************************************
   // Controller state machine
   // ****************************************
   jtctap_state_t state_ff;
   jtctap_state_t nxt_state;

   always_comb begin
      case (state_ff)
         ST_RESET: nxt_state = tms_s ? ST_RESET : ST_IDLE;
         ST_IDLE: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: nxt_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: nxt_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: nxt_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: nxt_state = tms_s ? ST_UPDATE_DR : ST_PAUSE_DR;
         ST_PAUSE_DR: nxt_state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: nxt_state = tms_s ? ST_UPDATE_DR : ST_SHIFT_DR;
         ST_UPDATE_DR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: nxt_state = tms_s ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: nxt_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: nxt_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: nxt_state = tms_s ? ST_UPDATE_IR : ST_PAUSE_IR;
         ST_PAUSE_IR: nxt_state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: nxt_state = tms_s ? ST_UPDATE_IR : ST_SHIFT_IR;
         ST_UPDATE_IR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
         default: nxt_state = ST_RESET;
      endcase
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state_ff <= ST_RESET;
      end else if (!trst_n_s) begin
         state_ff <= ST_RESET;
      end else if (tck_rise) begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************
   // State decodes
   // ****************************************
   logic in_reset;
   logic in_cap_dr;
   logic in_shift_dr;
   logic in_upd_dr;
   logic in_cap_ir;
   logic in_shift_ir;
   logic in_upd_ir;

   assign in_reset = (state_ff == ST_RESET);
   assign in_cap_dr = (state_ff == ST_CAP_DR);
   assign in_shift_dr = (state_ff == ST_SHIFT_DR);
   assign in_upd_dr = (state_ff == ST_UPDATE_DR);
   assign in_cap_ir = (state_ff == ST_CAP_IR);
   assign in_shift_ir = (state_ff == ST_SHIFT_IR);
   assign in_upd_ir = (state_ff == ST_UPDATE_IR);

   // ****************************************
   // Instruction register
   // ****************************************
   logic [IR_WIDTH-1:0] ir_shift_ff;
   logic [IR_WIDTH-1:0] ir_cur_ff;

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ir_shift_ff <= IR_CAPTURE_VALUE;
      end else if (tck_rise && in_cap_ir) begin
         ir_shift_ff <= IR_CAPTURE_VALUE;
      end else if (tck_rise && in_shift_ir) begin
         ir_shift_ff <= {tdi_s, ir_shift_ff[IR_WIDTH-1:1]};
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ir_cur_ff <= INS_IDCODE;
      end else if (in_reset) begin
         ir_cur_ff <= INS_IDCODE;
      end else if (tck_fall && in_upd_ir) begin
         ir_cur_ff <= ir_shift_ff;
      end
   end

   // ****************************************
   // Instruction decode
   // ****************************************
   logic sel_bsr;
   logic sel_id;
   logic sel_bypass;
   logic ins_extest;
   logic ins_clamp;
   logic ins_highz;

   // Unknown codes fall back to the bypass path
   assign sel_bsr = (ir_cur_ff == INS_SAMPLE) || (ir_cur_ff == INS_EXTEST);
   assign sel_id = (ir_cur_ff == INS_IDCODE);
   assign sel_bypass = ~sel_bsr & ~sel_id;
   assign ins_extest = (ir_cur_ff == INS_EXTEST);
   assign ins_clamp = (ir_cur_ff == INS_CLAMP);
   assign ins_highz = (ir_cur_ff == INS_HIGHZ);

   // ****************************************
   // Data registers
   // ****************************************
   logic bypass_ff;
   logic [ID_WIDTH-1:0] id_shift_ff;
   logic [BSR_WIDTH-1:0] bsr_shift_ff;
   logic [BSR_WIDTH-1:0] bsr_latch_ff;
   logic [ID_WIDTH-1:0] id_value;
   logic dr_cap;
   logic dr_shift;

   assign id_value = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
   assign dr_cap = tck_rise & in_cap_dr;
   assign dr_shift = tck_rise & in_shift_dr;

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         bypass_ff <= 1'b0;
      end else if (dr_cap && sel_bypass) begin
         bypass_ff <= 1'b0;
      end else if (dr_shift && sel_bypass) begin
         bypass_ff <= tdi_s;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         id_shift_ff <= '0;
      end else if (dr_cap && sel_id) begin
         id_shift_ff <= id_value;
      end else if (dr_shift && sel_id) begin
         id_shift_ff <= {tdi_s, id_shift_ff[ID_WIDTH-1:1]};
      end
   end

   // Capture loads core outputs under SAMPLE, pin inputs under EXTEST
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         bsr_shift_ff <= '0;
      end else if (dr_cap && sel_bsr) begin
         bsr_shift_ff <= ins_extest ? PIN_IN : CORE_OUT_IN;
      end else if (dr_shift && sel_bsr) begin
         bsr_shift_ff <= {tdi_s, bsr_shift_ff[BSR_WIDTH-1:1]};
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         bsr_latch_ff <= '0;
      end else if (tck_fall && in_upd_dr && sel_bsr) begin
         bsr_latch_ff <= bsr_shift_ff;
      end
   end

   // ****************************************
   // Serial output
   // ****************************************
   logic dr_tail;
   logic nxt_tdo;
   logic nxt_tdo_oe_n;

   assign dr_tail = sel_bsr ? bsr_shift_ff[0] : (sel_id ? id_shift_ff[0] : bypass_ff);
   assign nxt_tdo = in_shift_ir ? ir_shift_ff[0] : dr_tail;
   assign nxt_tdo_oe_n = ~(in_shift_ir | in_shift_dr);

   // Serial out changes on the falling tap edge
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         TAP_SERIAL_OUT <= 1'b0;
         TAP_SERIAL_OE_N_OUT <= 1'b1;
      end else if (tck_fall) begin
         TAP_SERIAL_OUT <= nxt_tdo;
         TAP_SERIAL_OE_N_OUT <= nxt_tdo_oe_n;
      end
   end

   // ****************************************
   // Pin muxing
   // ****************************************
   logic test_drive;
   logic [BSR_WIDTH-1:0] nxt_pin;

   assign test_drive = ins_extest | ins_clamp;
   assign nxt_pin = test_drive ? bsr_latch_ff : CORE_OUT_IN;

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         PIN_OUT <= '0;
         PIN_OE_N_OUT <= 1'b0;
         CORE_IN_OUT <= '0;
         INSTRUCTION_OUT <= INS_IDCODE;
         TAP_RESET_STATE_OUT <= 1'b1;
      end else begin
         PIN_OUT <= nxt_pin;
         PIN_OE_N_OUT <= ins_highz;
         CORE_IN_OUT <= PIN_IN;
         INSTRUCTION_OUT <= ir_cur_ff;
         TAP_RESET_STATE_OUT <= in_reset;
      end
   end

endmodule

// [verif/jtctap_tester.sv]
`timescale 1ns/1ps
module jtctap_tester (
   input wire logic clk_in,
   input wire logic tdo_in,
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out
);
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end
   // ********
   // One 80 ns tap period, clock parked low after it
   // ********
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tms_out = tms;
      tdi_out = tdi;
      repeat (4) @(posedge clk_in);
      #1 tck_out = 1'b1;
      repeat (4) @(posedge clk_in);
      #1 tdo = tdo_in;
      tck_out = 1'b0;
   endtask
endmodule

// [verif/jtctap_checker_assertions.sv]
`timescale 1ns/1ps
module jtctap_checker
   import jtctap_pkg::*;
#(
   parameter int BSR_WIDTH = BSR_WIDTH_DEFAULT
) (
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic TAP_CLOCK_IN,
   input wire logic TAP_RESET_N_IN,
   input wire logic [BSR_WIDTH-1:0] CORE_OUT_IN,
   input wire logic [BSR_WIDTH-1:0] PIN_IN,
   input wire logic TAP_SERIAL_OUT,
   input wire logic [BSR_WIDTH-1:0] PIN_OUT,
   input wire logic PIN_OE_N_OUT,
   input wire logic [BSR_WIDTH-1:0] CORE_IN_OUT,
   input wire logic [IR_WIDTH-1:0] INSTRUCTION_OUT,
   input wire logic TAP_RESET_STATE_OUT
);
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RESET_N_IN);
   property p_trst;
      $fell(TAP_RESET_N_IN) |-> ##[1:6] TAP_RESET_STATE_OUT;
   endproperty
   a_trst: assert property (p_trst) else $error("tap reset missed");
   property p_tlr_ir;
      TAP_RESET_STATE_OUT [*3] |-> INSTRUCTION_OUT == INS_IDCODE;
   endproperty
   a_tlr_ir: assert property (p_tlr_ir) else $error("reset state instr");
   property p_hold;
      (TAP_RESET_N_IN && $stable(TAP_CLOCK_IN)) [*8] |->
         $stable(INSTRUCTION_OUT) && $stable(TAP_RESET_STATE_OUT);
   endproperty
   a_hold: assert property (p_hold) else $error("change without tap edge");
   property p_pins;
      $past(RESET_N_IN) && $stable(INSTRUCTION_OUT) && INSTRUCTION_OUT != INS_EXTEST &&
         INSTRUCTION_OUT != INS_CLAMP |-> PIN_OUT == $past(CORE_OUT_IN);
   endproperty
   a_pins: assert property (p_pins) else $error("pins not functional");
   property p_core;
      $past(RESET_N_IN) |-> CORE_IN_OUT == $past(PIN_IN);
   endproperty
   a_core: assert property (p_core) else $error("core input path");
   property p_highz;
      $past(RESET_N_IN) && $stable(INSTRUCTION_OUT) |->
         PIN_OE_N_OUT == (INSTRUCTION_OUT == INS_HIGHZ);
   endproperty
   a_highz: assert property (p_highz) else $error("pin enable");
   property p_clamp;
      INSTRUCTION_OUT == INS_CLAMP && $past(INSTRUCTION_OUT, 2) == INS_CLAMP |-> $stable(PIN_OUT);
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamped pins moved");
   property p_tdo;
      $changed(TAP_SERIAL_OUT) |->
         !$past(TAP_CLOCK_IN, 2) || !$past(TAP_CLOCK_IN, 3) || !$past(TAP_CLOCK_IN, 4);
   endproperty
   a_tdo: assert property (p_tdo) else $error("serial out off falling edge");
endmodule
bind jtctap_top jtctap_checker #(.BSR_WIDTH(BSR_WIDTH)) u_chk (.CLOCK_IN(CLOCK_IN),
   .RESET_N_IN(RESET_N_IN), .TAP_CLOCK_IN(TAP_CLOCK_IN), .TAP_RESET_N_IN(TAP_RESET_N_IN),
   .CORE_OUT_IN(CORE_OUT_IN), .PIN_IN(PIN_IN), .TAP_SERIAL_OUT(TAP_SERIAL_OUT),
   .PIN_OUT(PIN_OUT), .PIN_OE_N_OUT(PIN_OE_N_OUT), .CORE_IN_OUT(CORE_IN_OUT),
   .INSTRUCTION_OUT(INSTRUCTION_OUT), .TAP_RESET_STATE_OUT(TAP_RESET_STATE_OUT));

// [verif/jtag_tap_controller_bench.sv]
`timescale 1ns/1ps
module jtag_tap_controller_bench
   import jtctap_pkg::*;
();
   localparam logic [10:0] MAKER = 11'h2A5; // Arbitrary value
   localparam logic [15:0] PART = 16'h1234; // Arbitrary value
   localparam logic [3:0] VERS = 4'h6; // Arbitrary value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic trst_n = 1'b1;
   logic [7:0] core_o = 8'h00;
   logic [7:0] pin_i = 8'h00;
   logic tck, tms, tdi, tdo, tdo_oe_n, pin_oe_n, tlr;
   logic [7:0] pin_o, core_i;
   logic [2:0] instr;
   int error_cnt = 0;
   int total_checks = 0;
   always #5 clk = ~clk;
   jtctap_top #(.ID_MAKER(MAKER), .ID_PART(PART), .ID_VERSION(VERS)) dut (
      .CLOCK_IN(clk), .RESET_N_IN(rst_n), .TAP_CLOCK_IN(tck), .TAP_MODE_SELECT_IN(tms),
      .TAP_SERIAL_IN(tdi), .TAP_RESET_N_IN(trst_n), .CORE_OUT_IN(core_o), .PIN_IN(pin_i),
      .TAP_SERIAL_OUT(tdo), .TAP_SERIAL_OE_N_OUT(tdo_oe_n), .PIN_OUT(pin_o),
      .PIN_OE_N_OUT(pin_oe_n), .CORE_IN_OUT(core_i), .INSTRUCTION_OUT(instr),
      .TAP_RESET_STATE_OUT(tlr));
   jtctap_tester u_tst (.clk_in(clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
   // ********
   // Shared tasks
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s: %h vs %h", $time, what, got, exp);
      end
   endtask
   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic walk(input logic [7:0] seq, input int n);
      logic b;
      for (int i = 0; i < n; i++) u_tst.step(seq[i], 1'b0, b);
   endtask
   task automatic scan(input logic [31:0] din, input int n, output logic [31:0] dout);
      logic b;
      dout = 32'h0000_0000;
      for (int i = 0; i < n; i++) begin
         u_tst.step(i == n - 1, din[i], b);
         chk(tdo_oe_n, 1'b0, "serial enable");
         dout[i] = b;
      end
   endtask
   task automatic ir(input logic [2:0] code);
      logic [31:0] o;
      walk(8'h03, 4);
      scan({29'h0000_0000, code}, 3, o);
      chk(o, 32'h0000_0001, "ir capture");
      walk(8'h01, 2);
      chk(instr, code, "instruction");
      chk(tdo_oe_n, 1'b1, "serial released");
   endtask
   task automatic dr(input logic [31:0] din, input int n, output logic [31:0] dout);
      walk(8'h01, 3);
      scan(din, n, dout);
      walk(8'h01, 2);
   endtask
   task automatic end_sim;
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ********
   // Scenarios
   // ********
   task automatic t_power;
      core_o = 8'h96;
      pin_i = 8'h69;
      settle;
      chk(tlr, 1'b1, "tlr");
      chk(instr, INS_IDCODE, "instr");
      chk(pin_o, 8'h96, "pins");
      chk(core_i, 8'h69, "core");
   endtask
   task automatic t_idcode;
      logic [31:0] o;
      walk(8'h00, 1);
      settle;
      chk(tlr, 1'b0, "left tlr");
      dr(32'h0000_0000, 32, o);
      chk(o, {VERS, PART, MAKER, 1'b1}, "idcode");
   endtask
   task automatic t_codes;
      logic [2:0] codes [6];
      codes = '{INS_SAMPLE, INS_BYPASS, INS_EXTEST, INS_CLAMP, INS_HIGHZ, INS_IDCODE};
      foreach (codes[i]) begin
         ir(codes[i]);
         chk(pin_oe_n, codes[i] == INS_HIGHZ, "highz");
      end
   endtask
   task automatic t_bypass;
      logic [31:0] a, b;
      ir(INS_BYPASS);
      walk(8'h00, 3);
      chk(instr, INS_BYPASS, "idle hold");
      walk(8'h01, 3);
      scan(32'h0000_0004, 4, a);
      walk(8'h04, 4);
      scan(32'h0000_000B, 4, b);
      walk(8'h01, 2);
      chk({b[3:0], a[3:0]}, 8'h68, "bypass");
   endtask
   task automatic t_boundary;
      logic [31:0] o;
      ir(INS_SAMPLE);
      core_o = 8'hA5;
      dr(32'h0000_003C, 8, o);
      chk(o, 32'h0000_00A5, "sample");
      chk(pin_o, 8'hA5, "pins");
      ir(INS_EXTEST);
      chk(pin_o, 8'h3C, "preload");
      pin_i = 8'h5A;
      walk(8'h01, 3);
      scan(32'h0000_00C3, 8, o);
      chk(pin_o, 8'h3C, "pins in shift");
      chk(o, 32'h0000_005A, "extest");
      walk(8'h01, 2);
      chk(pin_o, 8'hC3, "update");
      ir(INS_CLAMP);
      chk(pin_o, 8'hC3, "clamp");
   endtask
   task automatic t_five;
      walk(8'h03, 4);
      walk(8'h0F, 4);
      settle;
      chk(tlr, 1'b0, "four high");
      walk(8'h01, 1);
      settle;
      chk(tlr, 1'b1, "five high");
      chk(instr, INS_IDCODE, "tlr instr");
      walk(8'h00, 1);
   endtask
   task automatic t_trst;
      ir(INS_BYPASS);
      trst_n = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      chk(tlr, 1'b1, "trst");
      chk(instr, INS_IDCODE, "trst instr");
      trst_n = 1'b1;
      settle;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      settle;
      t_power;
      t_idcode;
      t_codes;
      t_bypass;
      t_boundary;
      t_five;
      t_trst;
      end_sim;
   end
   initial begin
      #200000;
      error_cnt++;
      end_sim;
   end
endmodule
